// *** hw/pba_regs.svh ***
// Purpose: register map, field positions and constants of the averager
// Assumes: 32-bit APB, byte addresses, one word per register
// Notes: definitions only
`ifndef PBA_REGS_SVH
`define PBA_REGS_SVH
`define PBA_ADDR_CTRL      12'h000
`define PBA_ADDR_STATUS    12'h004
`define PBA_ADDR_ZOOM_W    12'h008
`define PBA_ADDR_BOX_START 12'h00c
`define PBA_ADDR_BOX_WIDTH 12'h010
`define PBA_ADDR_BASE_POS  12'h014
`define PBA_ADDR_BOX_VAL   12'h018
`define PBA_ADDR_BIN_SEL   12'h01c
`define PBA_ADDR_BIN_VAL   12'h020
`define PBA_ADDR_ZOOM_HARM 12'h024
`define PBA_ADDR_LOCK_TOL  12'h028
`define PBA_ADDR_BIN_SUM   12'h02c
`define PBA_ADDR_BIN_CNT   12'h030
`define PBA_ADDR_PER       12'h034
// control bits
`define PBA_CTRL_RUN     0
`define PBA_CTRL_EXTERNAL_REFERENCE_MODE  1
`define PBA_CTRL_ZOOM    2
`define PBA_CTRL_HARMON  3
`define PBA_CTRL_BASE    4
`define PBA_CTRL_SUBH    5
`define PBA_CTRL_START   6
// status bits
`define PBA_ST_LOCK      0
`define PBA_ST_COMMENS   1
`define PBA_ST_BASE_OOR  2
`define PBA_ST_FIFO_OVF  3
// phase: 32-bit accumulator, top 10 bits = bin; 360 deg = 2^32
`define PBA_NBINS        1024
`define PBA_BIN_W        10
`define PBA_PH_W         32
`define PBA_PH_MSB       31
`define PBA_BIN_LSB      22
// commensurability check: period in sample clocks divides this
`define PBA_COMMENS_MOD  32'h0000_0168
// baseline limit: shortest trigger period in samples (450 MHz at 1 sample)
`define PBA_MIN_PER      32'h0000_0001
`define PBA_LOCK_TOL_RST 32'h0000_0004
`define PBA_ZOOM_W_RST   32'hffff_ffff
`define PBA_ZOOM_H_RST   32'h0000_0001
`define PBA_FIFO_DEPTH   16
`define PBA_FIFO_AW      4
`define PBA_SAMP_W       16
`endif

// *** hw/pba_pkg.sv ***
// Purpose: types of the phase binned averager
// Assumes: constants live in pba_regs.svh
// Notes: none
package pba_pkg;
   typedef enum logic [2:0] {
      PBA_IDLE  = 3'b001,
      PBA_CLEAR = 3'b010,
      PBA_RUN   = 3'b100
   } pba_state_t;
endpackage

// *** hw/pba_fifo.sv ***
// Purpose: sample fifo between input and averager
// Assumes: single clock
// Notes: valid/ready on both sides, honest full and empty
`timescale 1ns/100ps
module pba_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr_r;
   logic [AW:0] rd_ptr_r;
   logic full;
   logic empty;
   assign empty = (wr_ptr_r == rd_ptr_r);
   assign full = (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]) &&
                 (wr_ptr_r[AW] != rd_ptr_r[AW]);
   assign in_ready_o = !full;
   assign out_valid_o = !empty;
   assign out_data_o = mem[rd_ptr_r[AW-1:0]];
   always_ff @(posedge clk_sys_i) begin
      if (in_valid_i && !full) begin
         mem[wr_ptr_r[AW-1:0]] <= in_data_i;
      end
   end
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wr_ptr_r <= '0;
      end else if (in_valid_i && !full) begin
         wr_ptr_r <= wr_ptr_r + 1'b1;
      end
   end
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rd_ptr_r <= '0;
      end else if (out_ready_i && !empty) begin
         rd_ptr_r <= rd_ptr_r + 1'b1;
      end
   end
endmodule

// *** hw/pba_top.sv ***
// Purpose: phase binned waveform averager with boxcar integrator
// Assumes: samples arrive on clk_sys_i; trigger pin is asynchronous
// Notes: phase is a 32-bit accumulator, 2^32 is one full period
`timescale 1ns/100ps
`include "pba_regs.svh"
module pba_top (
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic trig_i,
   input wire logic [`PBA_SAMP_W-1:0] samp_data_i,
   input wire logic samp_valid_i,
   output logic samp_ready_o,
   output logic lock_o,
   output logic commens_warn_o
);
   // ****************************************************************
   // registers
   // ****************************************************************
   logic [6:0] ctrl_r;
   logic [31:0] zoom_w_r;
   logic [31:0] zoom_h_r;
   logic [31:0] box_start_r;
   logic [31:0] box_width_r;
   logic [31:0] base_pos_r;
   logic [31:0] lock_tol_r;
   logic [`PBA_BIN_W-1:0] bin_sel_r;
   logic [31:0] prdata_r;
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   pba_pkg::pba_state_t state_r;
   logic lock_r;
   logic commens_r;
   logic base_oor_r;
   logic ovf_r;
   logic [31:0] per_r;
   logic [31:0] box_val_r;
   logic [31:0] bin_sum_q;
   logic [31:0] bin_cnt_q;

   assign wr_en = psel_i && penable_i && pwrite_i;
   assign rd_en = psel_i && penable_i && !pwrite_i;
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i && penable_i && !addr_ok;
   assign prdata_o = prdata_r;

   always_comb begin
      unique case (paddr_i)
         `PBA_ADDR_CTRL, `PBA_ADDR_STATUS, `PBA_ADDR_ZOOM_W,
         `PBA_ADDR_BOX_START, `PBA_ADDR_BOX_WIDTH, `PBA_ADDR_BASE_POS,
         `PBA_ADDR_BOX_VAL, `PBA_ADDR_BIN_SEL, `PBA_ADDR_BIN_VAL,
         `PBA_ADDR_ZOOM_HARM, `PBA_ADDR_LOCK_TOL, `PBA_ADDR_BIN_SUM,
         `PBA_ADDR_BIN_CNT, `PBA_ADDR_PER: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   // start bit is self clearing; it acts as a one-cycle pulse
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ctrl_r <= '0;
         zoom_w_r <= `PBA_ZOOM_W_RST;
         zoom_h_r <= `PBA_ZOOM_H_RST;
         box_start_r <= '0;
         box_width_r <= '0;
         base_pos_r <= '0;
         lock_tol_r <= `PBA_LOCK_TOL_RST;
         bin_sel_r <= '0;
      end else begin
         ctrl_r[`PBA_CTRL_START] <= 1'b0;
         if (wr_en) begin
            unique case (paddr_i)
               `PBA_ADDR_CTRL: ctrl_r <= pwdata_i[6:0];
               `PBA_ADDR_ZOOM_W: zoom_w_r <= pwdata_i;
               `PBA_ADDR_ZOOM_HARM: zoom_h_r <= pwdata_i;
               `PBA_ADDR_BOX_START: box_start_r <= pwdata_i;
               `PBA_ADDR_BOX_WIDTH: box_width_r <= pwdata_i;
               `PBA_ADDR_BASE_POS: base_pos_r <= pwdata_i;
               `PBA_ADDR_LOCK_TOL: lock_tol_r <= pwdata_i;
               `PBA_ADDR_BIN_SEL: bin_sel_r <= pwdata_i[`PBA_BIN_W-1:0];
               default: ;
            endcase
         end
      end
   end

   // ****************************************************************
   // trigger synchroniser and period measurement
   // ****************************************************************
   logic [2:0] trig_sync_r;
   logic trig_lvl_r;
   logic trig_rise;
   logic [31:0] per_cnt_r;
   logic sub_tgl_r;
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         trig_sync_r <= '0;
         trig_lvl_r <= 1'b0;
      end else begin
         trig_sync_r <= {trig_sync_r[1:0], trig_i};
         if (trig_sync_r[1] == trig_sync_r[2]) begin
            trig_lvl_r <= trig_sync_r[2];
         end
      end
   end
   assign trig_rise = (trig_sync_r[1] == trig_sync_r[2]) &&
                      trig_sync_r[2] && !trig_lvl_r;

   // with the subharmonic bit set only every second trigger closes a period
   logic per_edge;
   assign per_edge = trig_rise && (!ctrl_r[`PBA_CTRL_SUBH] || sub_tgl_r);
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sub_tgl_r <= 1'b0;
         per_cnt_r <= '0;
         per_r <= '0;
      end else begin
         if (trig_rise) begin
            sub_tgl_r <= !sub_tgl_r;
         end
         if (per_edge) begin
            per_r <= per_cnt_r + 32'h1;
            per_cnt_r <= '0;
         end else if (per_cnt_r != 32'hffff_ffff) begin
            per_cnt_r <= per_cnt_r + 32'h1;
         end
      end
   end

   // ****************************************************************
   // oscillator locked to trigger
   // ****************************************************************
   logic [31:0] ph_r;
   logic [31:0] step_r;
   logic [31:0] diff;
   // step = 2^32 / period, found by a restoring divider once per period
   logic [31:0] div_q_r;
   logic [32:0] div_rem_r;
   logic [5:0] div_cnt_r;
   logic div_busy_r;
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         div_q_r <= '0;
         div_rem_r <= '0;
         div_cnt_r <= '0;
         div_busy_r <= 1'b0;
         step_r <= '0;
      end else if (per_edge && ctrl_r[`PBA_CTRL_EXTERNAL_REFERENCE_MODE]) begin
         div_busy_r <= 1'b1;
         div_cnt_r <= 6'h21;
         div_q_r <= '0;
         div_rem_r <= 33'h1;
      end else if (div_busy_r) begin
         if (div_rem_r >= {1'b0, per_r}) begin
            div_rem_r <= {div_rem_r[31:0] - per_r, 1'b0};
            div_q_r <= {div_q_r[30:0], 1'b1};
         end else begin
            div_rem_r <= {div_rem_r[31:0], 1'b0};
            div_q_r <= {div_q_r[30:0], 1'b0};
         end
         div_cnt_r <= div_cnt_r - 6'h1;
         if (div_cnt_r == 6'h0) begin
            div_busy_r <= 1'b0;
            step_r <= div_q_r;
         end
      end
   end

   // phase re-aligned to zero on each closing trigger in external reference mode
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ph_r <= '0;
      end else if (per_edge && ctrl_r[`PBA_CTRL_EXTERNAL_REFERENCE_MODE]) begin
         ph_r <= '0;
      end else begin
         ph_r <= ph_r + step_r;
      end
   end

   // lock: measured period stable within tolerance between triggers
   logic [31:0] per_prev_r;
   assign diff = (per_r > per_prev_r) ? per_r - per_prev_r
                                      : per_prev_r - per_r;
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         per_prev_r <= '0;
         lock_r <= 1'b0;
      end else if (!ctrl_r[`PBA_CTRL_EXTERNAL_REFERENCE_MODE]) begin
         lock_r <= 1'b0;
      end else if (per_edge) begin
         per_prev_r <= per_r;
         lock_r <= (diff <= lock_tol_r) && (per_r != 32'h0);
      end
   end
   assign lock_o = lock_r;

   // commensurable when the period divides the reference modulus
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         commens_r <= 1'b0;
         base_oor_r <= 1'b0;
      end else begin
         commens_r <= (per_r != 32'h0) &&
                      ((`PBA_COMMENS_MOD % per_r) == 32'h0);
         base_oor_r <= ctrl_r[`PBA_CTRL_BASE] &&
                       (per_r < `PBA_MIN_PER);
      end
   end
   assign commens_warn_o = commens_r;

   // ****************************************************************
   // sample fifo and binning
   // ****************************************************************
   logic [`PBA_SAMP_W-1:0] fifo_data;
   logic fifo_valid;
   logic fifo_ready;
   pba_fifo #(
      .WIDTH(`PBA_SAMP_W),
      .DEPTH(`PBA_FIFO_DEPTH),
      .AW(`PBA_FIFO_AW)
   ) u_fifo (
      .clk_sys_i(clk_sys_i),
      .arst_n_i(arst_n_i),
      .in_data_i(samp_data_i),
      .in_valid_i(samp_valid_i),
      .in_ready_o(samp_ready_o),
      .out_data_o(fifo_data),
      .out_valid_o(fifo_valid),
      .out_ready_i(fifo_ready)
   );

   function automatic logic in_win(input logic [31:0] ph,
                                   input logic [31:0] st,
                                   input logic [31:0] w);
      logic [31:0] off;
      off = ph - st;
      return off < w;
   endfunction

   logic [31:0] ph_eff;
   logic [31:0] ph_rel;
   logic [63:0] zprod;
   logic zoom_in;
   logic [`PBA_BIN_W-1:0] bin_idx;
   always_comb begin
      ph_eff = ph_r;
      if (ctrl_r[`PBA_CTRL_HARMON] || ctrl_r[`PBA_CTRL_ZOOM]) begin
         ph_eff = 32'(ph_r * zoom_h_r);
      end
      ph_rel = ph_eff - box_start_r;
      zoom_in = ph_rel < zoom_w_r;
      zprod = {32'h0, ph_rel} * 64'({22'h0, 10'h3ff} + 32'h1);
      if (ctrl_r[`PBA_CTRL_ZOOM]) begin
         bin_idx = `PBA_BIN_W'(zprod / {32'h0, zoom_w_r});
      end else begin
         bin_idx = ph_eff[`PBA_PH_MSB:`PBA_BIN_LSB];
      end
   end

   logic [31:0] bin_sum [`PBA_NBINS];
   logic [31:0] bin_cnt [`PBA_NBINS];
   logic [`PBA_BIN_W-1:0] clr_idx_r;
   logic take;
   assign fifo_ready = (state_r != pba_pkg::PBA_CLEAR);
   assign take = fifo_valid && (state_r == pba_pkg::PBA_RUN) &&
                 (!ctrl_r[`PBA_CTRL_ZOOM] || zoom_in);

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_r <= pba_pkg::PBA_IDLE;
         clr_idx_r <= '0;
      end else begin
         unique case (state_r)
            pba_pkg::PBA_IDLE: if (ctrl_r[`PBA_CTRL_START]) begin
               state_r <= pba_pkg::PBA_CLEAR;
               clr_idx_r <= '0;
            end
            pba_pkg::PBA_CLEAR: begin
               clr_idx_r <= clr_idx_r + `PBA_BIN_W'(1);
               if (&clr_idx_r) begin
                  state_r <= pba_pkg::PBA_RUN;
               end
            end
            pba_pkg::PBA_RUN: if (!ctrl_r[`PBA_CTRL_RUN]) begin
               state_r <= pba_pkg::PBA_IDLE;
            end else if (ctrl_r[`PBA_CTRL_START]) begin
               state_r <= pba_pkg::PBA_CLEAR;
               clr_idx_r <= '0;
            end
            default: state_r <= pba_pkg::PBA_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (state_r == pba_pkg::PBA_CLEAR) begin
         bin_sum[clr_idx_r] <= '0;
         bin_cnt[clr_idx_r] <= '0;
      end else if (take) begin
         bin_sum[bin_idx] <= bin_sum[bin_idx] +
                             {{16{fifo_data[15]}}, fifo_data};
         bin_cnt[bin_idx] <= bin_cnt[bin_idx] + 32'h1;
      end
   end
   assign bin_sum_q = bin_sum[bin_sel_r];
   assign bin_cnt_q = bin_cnt[bin_sel_r];

   // ****************************************************************
   // boxcar integrator with baseline
   // ****************************************************************
   logic [31:0] gate_acc_r;
   logic [31:0] base_acc_r;
   logic [31:0] gate_n_r;
   logic [31:0] sval;
   logic box_run;
   assign sval = {{16{fifo_data[15]}}, fifo_data};
   assign box_run = fifo_valid && fifo_ready &&
                    (state_r == pba_pkg::PBA_RUN);
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         gate_acc_r <= '0;
         base_acc_r <= '0;
         gate_n_r <= '0;
         box_val_r <= '0;
      end else if (per_edge) begin
         // normalise per period; sum over count gives the mean sample code
         if (gate_n_r != 32'h0) begin
            box_val_r <= 32'($signed(
               ctrl_r[`PBA_CTRL_BASE] && !base_oor_r ?
               gate_acc_r - base_acc_r : gate_acc_r) /
               $signed(gate_n_r));
         end
         gate_acc_r <= '0;
         base_acc_r <= '0;
         gate_n_r <= '0;
      end else if (box_run) begin
         if (in_win(ph_r, box_start_r, box_width_r)) begin
            gate_acc_r <= gate_acc_r + sval;
            gate_n_r <= gate_n_r + 32'h1;
         end
         if (in_win(ph_r, base_pos_r, box_width_r)) begin
            base_acc_r <= base_acc_r + sval;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ovf_r <= 1'b0;
      end else if (samp_valid_i && !samp_ready_o) begin
         ovf_r <= 1'b1;
      end else if (wr_en && paddr_i == `PBA_ADDR_STATUS) begin
         ovf_r <= 1'b0;
      end
   end

   // ****************************************************************
   // read mux
   // ****************************************************************
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         prdata_r <= '0;
      end else if (psel_i && !penable_i && !pwrite_i) begin
         unique case (paddr_i)
            `PBA_ADDR_CTRL: prdata_r <= {25'h0, ctrl_r};
            `PBA_ADDR_STATUS: prdata_r <= {28'h0, ovf_r, base_oor_r,
                                           commens_r, lock_r};
            `PBA_ADDR_ZOOM_W: prdata_r <= zoom_w_r;
            `PBA_ADDR_ZOOM_HARM: prdata_r <= zoom_h_r;
            `PBA_ADDR_BOX_START: prdata_r <= box_start_r;
            `PBA_ADDR_BOX_WIDTH: prdata_r <= box_width_r;
            `PBA_ADDR_BASE_POS: prdata_r <= base_pos_r;
            `PBA_ADDR_BOX_VAL: prdata_r <= box_val_r;
            `PBA_ADDR_BIN_SEL: prdata_r <= {22'h0, bin_sel_r};
            `PBA_ADDR_BIN_VAL: prdata_r <= (bin_cnt_q == 32'h0) ? 32'h0 :
               32'($signed(bin_sum_q) / $signed(bin_cnt_q));
            `PBA_ADDR_LOCK_TOL: prdata_r <= lock_tol_r;
            `PBA_ADDR_BIN_SUM: prdata_r <= bin_sum_q;
            `PBA_ADDR_BIN_CNT: prdata_r <= bin_cnt_q;
            `PBA_ADDR_PER: prdata_r <= per_r;
            default: prdata_r <= '0;
         endcase
      end
   end
endmodule

// *** dv/pba_src_model.sv ***
// Purpose: trigger source and sample stream feeding the averager
// Assumes: one clock, outputs change just after the rising edge
// Notes: trigger stands low while disabled
`timescale 1ns/100ps
`include "pba_regs.svh"
module pba_src_model (
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   input wire logic [15:0] per_i,
   input wire logic trig_en_i,
   input wire logic samp_en_i,
   input wire logic [`PBA_SAMP_W-1:0] samp_val_i,
   output logic trig_o,
   output logic [`PBA_SAMP_W-1:0] samp_data_o,
   output logic samp_valid_o
);
   logic [15:0] cnt_r;
   // *********
   // trigger: high for half of each period of per_i clocks
   // *********
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_r <= 16'h0;
         trig_o <= 1'b0;
      end else if (!trig_en_i) begin
         cnt_r <= 16'h0;
         trig_o <= 1'b0;
      end else begin
         cnt_r <= (cnt_r >= per_i - 16'h1) ? 16'h0 : cnt_r + 16'h1;
         trig_o <= (cnt_r < (per_i >> 1));
      end
   end
   // idle data keeps toggling so a stale word never looks valid
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         samp_data_o <= 16'h0;
         samp_valid_o <= 1'b0;
      end else begin
         samp_valid_o <= samp_en_i;
         samp_data_o <= samp_en_i ? samp_val_i : ~samp_data_o;
      end
   end
endmodule

// *** dv/pba_top_properties.sv ***
// Purpose: port level checks of pba_top
// Assumes: one clock domain, async active low reset
// Notes: bound to every pba_top instance
`timescale 1ns/100ps
`include "pba_regs.svh"
module pba_top_chk (
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic trig_i,
   input wire logic [`PBA_SAMP_W-1:0] samp_data_i,
   input wire logic samp_valid_i,
   input wire logic samp_ready_o,
   input wire logic lock_o,
   input wire logic commens_warn_o
);
   logic ext_r;
   logic trig_q;
   logic [31:0] cnt_r;
   logic [31:0] per_r;
   logic acc;
   assign acc = psel_i & penable_i;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);
   // *********
   // helpers: mode bit mirror and trigger period
   // *********
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ext_r <= 1'b0;
      end else if (acc && pwrite_i && paddr_i == `PBA_ADDR_CTRL) begin
         ext_r <= pwdata_i[`PBA_CTRL_EXTERNAL_REFERENCE_MODE];
      end
   end
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         trig_q <= 1'b0;
         cnt_r <= 32'h0;
         per_r <= 32'h0;
      end else begin
         trig_q <= trig_i;
         if (trig_i && !trig_q) begin
            per_r <= cnt_r;
            cnt_r <= 32'h1;
         end else begin
            cnt_r <= cnt_r + 32'h1;
         end
      end
   end
   a_pready_zero_wait: assert property (acc |-> pready_o)
      else $error("pready low in access phase");
   a_err_in_access: assert property (pslverr_o |-> acc)
      else $error("pslverr outside access phase");
   a_unmapped_err: assert property (acc && paddr_i > `PBA_ADDR_PER
      |-> pslverr_o)
      else $error("unmapped access without pslverr");
   a_mapped_ok: assert property (acc && paddr_i <= `PBA_ADDR_PER
      && paddr_i[1:0] == 2'b00 |-> !pslverr_o)
      else $error("pslverr on mapped register");
   a_unmapped_zero: assert property (acc && !pwrite_i
      && paddr_i > `PBA_ADDR_PER |-> prdata_o == 32'h0)
      else $error("unmapped read not zero");
   a_full_by_push: assert property ($fell(samp_ready_o)
      |-> $past(samp_valid_i))
      else $error("fifo became full without a push");
   a_lock_needs_ext: assert property (!ext_r && !$past(ext_r)
      && !$past(ext_r, 2) |-> !lock_o)
      else $error("lock high outside external reference mode");
   a_warn_divides: assert property ($rose(commens_warn_o) |->
      per_r != 32'h0 && `PBA_COMMENS_MOD % per_r == 32'h0)
      else $error("warning raised for a non dividing period");
   a_flags_reset: assert property ($rose(arst_n_i)
      |-> !lock_o && !commens_warn_o)
      else $error("flags set right after reset");
   c_lock: cover property ($rose(lock_o));
   c_warn: cover property ($rose(commens_warn_o));
   c_full: cover property ($fell(samp_ready_o));
   c_err: cover property (pslverr_o);
endmodule
bind pba_top pba_top_chk u_chk (
   .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .trig_i(trig_i), .samp_data_i(samp_data_i),
   .samp_valid_i(samp_valid_i), .samp_ready_o(samp_ready_o),
   .lock_o(lock_o), .commens_warn_o(commens_warn_o));

// *** dv/pba_top_tb_top.sv ***
// Purpose: self checking bench of pba_top
// Assumes: 10 MHz clock, zero wait APB slave
// Notes: constant samples make every bin and gate mean predictable
`timescale 1ns/100ps
`include "pba_regs.svh"
module pba_top_tb_top;
   typedef struct packed {
      logic wr;
      logic [11:0] a;
      logic [31:0] wd;
      logic [31:0] ex;
      logic er;
   } pba_row_t;
   logic clk, rst_n, psel, pen, pwr, pready, pslverr, trig, svalid;
   logic sready, lock, warn, trig_en, samp_en, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] sdata, sval, per;
   int err_total = 0;
   int tests_run = 0;
   int n;
   pba_row_t rows [12] = '{
      '{1'b0, `PBA_ADDR_LOCK_TOL, 32'h0, `PBA_LOCK_TOL_RST, 1'b0},
      '{1'b0, `PBA_ADDR_ZOOM_W, 32'h0, `PBA_ZOOM_W_RST, 1'b0},
      '{1'b0, `PBA_ADDR_ZOOM_HARM, 32'h0, `PBA_ZOOM_H_RST, 1'b0},
      '{1'b0, `PBA_ADDR_STATUS, 32'h0, 32'h0, 1'b0},
      '{1'b1, `PBA_ADDR_BOX_START, 32'h2000_0000, 32'h0, 1'b0},
      '{1'b0, `PBA_ADDR_BOX_START, 32'h0, 32'h2000_0000, 1'b0},
      '{1'b1, `PBA_ADDR_BOX_WIDTH, 32'h4000_0000, 32'h0, 1'b0},
      '{1'b0, `PBA_ADDR_BOX_WIDTH, 32'h0, 32'h4000_0000, 1'b0},
      '{1'b1, `PBA_ADDR_BASE_POS, 32'h8000_0000, 32'h0, 1'b0},
      '{1'b0, `PBA_ADDR_BASE_POS, 32'h0, 32'h8000_0000, 1'b0},
      '{1'b1, 12'h0fc, 32'h5a5a_5a5a, 32'h0, 1'b1},
      '{1'b0, 12'h0fc, 32'h0, 32'h0, 1'b1}};
   pba_top uut (.clk_sys_i(clk), .arst_n_i(rst_n), .psel_i(psel),
      .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .trig_i(trig), .samp_data_i(sdata), .samp_valid_i(svalid),
      .samp_ready_o(sready), .lock_o(lock), .commens_warn_o(warn));
   pba_src_model u_src (.clk_sys_i(clk), .arst_n_i(rst_n), .per_i(per),
      .trig_en_i(trig_en), .samp_en_i(samp_en), .samp_val_i(sval),
      .trig_o(trig), .samp_data_o(sdata), .samp_valid_o(svalid));
   // *********
   // tasks
   // *********
   task automatic chk(input string nm, input logic [31:0] s,
      input logic [31:0] x);
      tests_run++;
      if (s !== x) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", nm, x, s);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      e = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic rchk(input string nm, input logic [11:0] a,
      input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(nm, rd, x);
   endtask
   // the bin hit by the phase steps is not fixed, so find a filled one
   task automatic bin_chk(input string nm, input logic [31:0] x);
      for (int b = 0; b < 64; b++) begin
         apb(1'b1, `PBA_ADDR_BIN_SEL, 32'(b));
         apb(1'b0, `PBA_ADDR_BIN_CNT, 32'h0);
         if (rd !== 32'h0) break;
      end
      chk({nm, "_cnt"}, 32'(rd != 32'h0), 32'h1);
      rchk(nm, `PBA_ADDR_BIN_VAL, x);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      repeat (60000) @(posedge clk);
      err_total++;
      wrap_up();
   end
   initial begin
      {rst_n, psel, pen, pwr, trig_en, samp_en} = 6'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      per = 16'd37;
      sval = 16'h0100;
      repeat (3) @(posedge clk);
      chk("rst_flags", {28'h0, pready, sready, lock, warn}, 32'hc);
      rst_n <= 1'b1;
      foreach (rows[i]) begin
         apb(rows[i].wr, rows[i].a, rows[i].wd);
         if (!rows[i].wr) chk("reg", rd, rows[i].ex);
         chk("err", 32'(e), 32'(rows[i].er));
      end
      trig_en <= 1'b1;
      apb(1'b1, `PBA_ADDR_CTRL, 32'h2);
      for (n = 0; n < 1000 && lock !== 1'b1; n++) @(posedge clk);
      chk("lock", 32'(lock), 32'h1);
      rchk("period", `PBA_ADDR_PER, 32'd37);
      chk("warn37", 32'(warn), 32'h0);
      per <= 16'd36;
      for (n = 0; n < 1000 && warn !== 1'b1; n++) @(posedge clk);
      repeat (200) @(posedge clk);
      chk("warn36", 32'(warn), 32'h1);
      rchk("st_warn", `PBA_ADDR_STATUS, 32'h3);
      per <= 16'd37;
      repeat (300) @(posedge clk);
      chk("warn_off", 32'(warn), 32'h0);
      samp_en <= 1'b1;
      apb(1'b1, `PBA_ADDR_CTRL, 32'h43);
      repeat (40) @(posedge clk);
      chk("full", 32'(sready), 32'h0);
      repeat (1100) @(posedge clk);
      rchk("ovf", `PBA_ADDR_STATUS, 32'h9);
      apb(1'b1, `PBA_ADDR_STATUS, 32'h0);
      rchk("ovf_clr", `PBA_ADDR_STATUS, 32'h1);
      repeat (2000) @(posedge clk);
      bin_chk("bin", 32'h100);
      rchk("box", `PBA_ADDR_BOX_VAL, 32'h100);
      apb(1'b1, `PBA_ADDR_CTRL, 32'h13);
      repeat (500) @(posedge clk);
      rchk("box_base", `PBA_ADDR_BOX_VAL, 32'h0);
      sval <= 16'h0200;
      // let stale samples drain from the fifo before the restart
      repeat (20) @(posedge clk);
      apb(1'b1, `PBA_ADDR_CTRL, 32'h53);
      repeat (3100) @(posedge clk);
      bin_chk("bin_new", 32'h200);
      apb(1'b1, `PBA_ADDR_CTRL, 32'h22);
      repeat (300) @(posedge clk);
      rchk("per_half", `PBA_ADDR_PER, 32'h4a);
      apb(1'b1, `PBA_ADDR_CTRL, 32'h0);
      repeat (8) @(posedge clk);
      chk("unlock", 32'(lock), 32'h0);
      rst_n <= 1'b0;
      @(posedge clk);
      chk("rst2_flags", {28'h0, pready, sready, lock, warn}, 32'hc);
      rst_n <= 1'b1;
      rchk("tol", `PBA_ADDR_LOCK_TOL, `PBA_LOCK_TOL_RST);
      wrap_up();
   end
endmodule
